// ### core_regs_status_stack_tb_top.sv
// Self-checking bench for the register, flag and stack pointer datapath.
`timescale 1ns/10ps
`default_nettype none
module core_regs_status_stack_tb_top;
    // ----------------------------------------
    // Signals, tasks and reference model
    // ----------------------------------------
    logic sys_clk, nrst, clk_en, wr_byte_en, wr_word_en, alu_en, alu_imm_sel, bit_store_op;
    logic bit_load_op, ptr_en, ds_wr, io_wr, flags_wr, push_op, pop_op, sub_call_op;
    logic sub_return_op, irq_return_op, irq_taken, set_irq_enable_op, clear_irq_enable_op;
    logic irq_pending, fetch_valid, fetch_run, ds_hit, io_hit, irq_accept;
    logic [4:0] rd_addr_a, rd_addr_b, rd_word_addr, wr_addr;
    logic [2:0] bit_sel;
    logic [1:0] ptr_sel;
    logic [5:0] ptr_disp, io_addr;
    logic [7:0] alu_imm, ds_wdata, io_wdata, flags_wdata, rd_data_a, rd_data_b, alu_result;
    logic [7:0] ds_rdata, io_rdata, status_flags, fl, v, a, b;
    logic [15:0] wr_data, ds_addr, fetch_word, rd_word, ptr_addr, stack_pointer, exec_word, e, w;
    logic [13:0] f;
    crs_pkg::crs_alu_op_t alu_op;
    crs_pkg::crs_ptr_mode_t ptr_mode;
    int error_cnt = 0;
    int num_checks = 0;
    int d[6] = '{-1, -2, -2, 1, 2, 2};
    logic [7:0] ca[4] = '{8'h80, 8'h0f, 8'h7f, 8'h00};
    logic [7:0] cb[4] = '{8'h80, 8'h01, 8'h01, 8'h00};
    crs_core_regs i_dut (.*);
    crs_fetch_model i_fetch (.sys_clk(sys_clk), .run(fetch_run), .fetch_valid(fetch_valid),
                             .fetch_word(fetch_word));
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle();
        {wr_byte_en, wr_word_en, alu_en, bit_store_op, bit_load_op, ptr_en, ds_wr, io_wr} = '0;
        {flags_wr, push_op, pop_op, sub_call_op, sub_return_op, irq_return_op, irq_taken} = '0;
        {set_irq_enable_op, clear_irq_enable_op} = '0;
    endtask
    // Strobes are held across one edge, then released with a quiet edge after them.
    task automatic pulse();
        tick();
        idle();
        tick();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wreg(input logic [4:0] ad, input logic [7:0] dv);
        {wr_addr, wr_data, wr_byte_en} = {ad, 8'h00, dv, 1'b1};
        pulse();
    endtask
    task automatic iow(input logic [5:0] ad, input logic [7:0] dv);
        {io_addr, io_wdata, io_wr} = {ad, dv, 1'b1};
        pulse();
    endtask
    task automatic pstep(input crs_pkg::crs_ptr_mode_t m, input logic [15:0] ea, ew);
        ptr_mode = m;
        tick();
        chk(ptr_addr, ea);
        ptr_en = 1'b1;
        pulse();
        chk(rd_word, ew);
    endtask
    function automatic logic [13:0] f_alu(input logic [7:0] x, input logic [7:0] y, input logic s);
        logic [7:0] r, p, q, t;
        logic h, c, o;
        r = s ? x - y : x + y;
        p = s ? ~x : x;
        q = s ? ~r : r;
        t = s ? ~y : y;
        h = (p[3] & y[3]) | (y[3] & ~q[3]) | (~q[3] & p[3]);
        c = (p[7] & y[7]) | (y[7] & ~q[7]) | (~q[7] & p[7]);
        o = (x[7] & t[7] & ~r[7]) | (~x[7] & ~t[7] & r[7]);
        return {h, r[7] ^ o, o, r[7], r == 8'h00, c, r};
    endfunction
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        void'($urandom(95));
        idle();
        {rd_addr_a, rd_addr_b, rd_word_addr, wr_addr, wr_data, alu_imm_sel, alu_imm, bit_sel} = '0;
        {ptr_sel, ptr_disp, ds_addr, ds_wdata, io_addr, io_wdata, flags_wdata, irq_pending} = '0;
        {fetch_run, nrst, clk_en} = 3'h1;
        alu_op = crs_pkg::CRS_OP_ADD;
        ptr_mode = crs_pkg::CRS_PTR_PLAIN;
        repeat (5) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        io_addr = 6'h3f;
        tick();
        chk(stack_pointer, 16'h0000);
        chk({io_hit, io_rdata}, 9'h000);
        iow(6'h3d, 8'hff);
        iow(6'h3e, 8'h08);
        chk({io_hit, io_rdata}, 9'h108);
        flags_wdata = 8'hff;
        flags_wr = 1'b1;
        pulse();
        fl = 8'hef;
        chk(status_flags, fl);
        e = 16'h08ff;
        for (int k = 0; k < 6; k++) begin
            {push_op, sub_call_op, irq_taken, pop_op, sub_return_op, irq_return_op} = 6'h20 >> k;
            pulse();
            e = e + 16'(d[k]);
            fl[7] = (k < 2 || k == 5);
            chk(stack_pointer, e);
            chk(status_flags, fl);
        end
        {clk_en, push_op} = 2'h1;
        pulse();
        clk_en = 1'b1;
        chk(stack_pointer, e);
        irq_pending = 1'b1;
        tick();
        chk(irq_accept, 16'h0001);
        clear_irq_enable_op = 1'b1;
        #1;
        chk(irq_accept, 16'h0000);
        pulse();
        chk(irq_accept, 16'h0000);
        set_irq_enable_op = 1'b1;
        pulse();
        chk(irq_accept, 16'h0001);
        irq_pending = 1'b0;
        done("stack and interrupt enable");
        for (int i = 0; i < 4; i++) begin
            {w, wr_addr} = {16'($urandom), 5'($urandom) & 5'h1e};
            {wr_data, wr_word_en} = {w, 1'b1};
            pulse();
            {rd_addr_a, rd_addr_b, rd_word_addr} = {wr_addr, wr_addr | 5'h01, wr_addr | 5'h01};
            ds_addr = {11'h000, wr_addr | 5'h01};
            tick();
            chk(rd_word, w);
            chk({rd_data_b, rd_data_a}, w);
            chk({ds_hit, ds_rdata}, {8'h01, w[15:8]});
        end
        {ds_addr, ds_wdata, ds_wr} = {16'h0005, 8'h5a, 1'b1};
        pulse();
        {rd_addr_a, ds_addr} = {5'h05, 16'h0020};
        tick();
        chk(rd_data_a, 8'h5a);
        chk({ds_hit, ds_rdata}, 9'h000);
        for (int s = 0; s < 3; s++) begin
            {w, wr_addr} = {16'($urandom), 5'h1a + 5'(2 * s)};
            {wr_data, wr_word_en} = {w, 1'b1};
            pulse();
            {rd_word_addr, ptr_sel, ptr_disp} = {wr_addr, 2'(s), 6'h3f};
            pstep(crs_pkg::CRS_PTR_DISP, w + 16'h003f, w);
            pstep(crs_pkg::CRS_PTR_POSTINC, w, w + 16'h0001);
            pstep(crs_pkg::CRS_PTR_PREDEC, w, w);
            pstep(crs_pkg::CRS_PTR_PLAIN, w, w);
        end
        done("register file and pointers");
        for (int i = 0; i < 16; i++) begin
            a = (i < 4) ? ca[i] : 8'($urandom);
            b = (i < 4) ? cb[i] : 8'($urandom);
            wreg(5'h03, a);
            wreg(5'h04, b);
            {rd_addr_a, rd_addr_b, alu_imm, alu_imm_sel} = {5'h03, 5'h04, b, i[1]};
            alu_op = !i[0] ? crs_pkg::CRS_OP_ADD :
                     i[2] ? crs_pkg::CRS_OP_CMP : crs_pkg::CRS_OP_SUB;
            f = f_alu(a, b, i[0]);
            tick();
            chk(alu_result, f[7:0]);
            alu_en = 1'b1;
            pulse();
            fl[5:0] = f[13:8];
            chk(rd_data_a, (i[0] && i[2]) ? a : f[7:0]);
            chk(status_flags, fl);
        end
        v = 8'($urandom);
        wreg(5'h07, v);
        rd_addr_a = 5'h07;
        for (int j = 0; j < 8; j++) begin
            {bit_sel, bit_store_op} = {3'(j), 1'b1};
            pulse();
            fl[6] = v[j];
            chk(status_flags, fl);
            {bit_sel, bit_load_op} = {3'(7 - j), 1'b1};
            pulse();
            v[7 - j] = fl[6];
            chk(rd_data_a, v);
        end
        done("arithmetic and bit copy");
        fetch_run = 1'b1;
        tick();
        tick();
        repeat (4) begin
            tick();
            chk(exec_word, fetch_word);
        end
        fetch_run = 1'b0;
        nrst = 1'b0;
        tick();
        nrst = 1'b1;
        chk(stack_pointer, 16'h0000);
        chk(exec_word, 16'h0000);
        done("prefetch and reset");
        finish_test();
    end
endmodule // core_regs_status_stack_tb_top
`default_nettype wire

// ### crs_alu.sv
// Single-cycle arithmetic unit producing a result and per-flag update mask.
`timescale 1ns/10ps
`default_nettype none
`include "crs_defines.svh"

module crs_alu (
    input  wire crs_pkg::crs_alu_op_t op,
    input  wire logic [7:0]           a,
    input  wire logic [7:0]           b,
    input  wire logic                 cin,
    input  wire logic                 zin,
    output logic [7:0]                res,
    output logic [7:0]                flag_val,
    output logic [7:0]                flag_mask,
    output logic                      writes
);
    logic [8:0] wide;
    logic       h;
    logic       v;
    logic       c;
    logic       zc;
    logic       sub;

    always_comb begin
        wide = 9'h000;
        h    = 1'b0;
        v    = 1'b0;
        c    = 1'b0;
        zc   = 1'b0;
        sub  = 1'b0;
        writes    = 1'b1;
        flag_mask = 8'h1e;
        unique case (op)
            crs_pkg::CRS_OP_ADD, crs_pkg::CRS_OP_ADC: begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, op == crs_pkg::CRS_OP_ADC && cin};
                flag_mask = 8'h3f;
            end
            crs_pkg::CRS_OP_SUB, crs_pkg::CRS_OP_CMP: begin
                wide = {1'b0, a} - {1'b0, b};
                sub  = 1'b1;
                flag_mask = 8'h3f;
                writes = (op == crs_pkg::CRS_OP_SUB);
            end
            crs_pkg::CRS_OP_SBC, crs_pkg::CRS_OP_CPC: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                sub  = 1'b1;
                zc   = 1'b1;
                flag_mask = 8'h3f;
                writes = (op == crs_pkg::CRS_OP_SBC);
            end
            crs_pkg::CRS_OP_AND: wide = {1'b0, a & b};
            crs_pkg::CRS_OP_OR:  wide = {1'b0, a | b};
            crs_pkg::CRS_OP_EOR: wide = {1'b0, a ^ b};
            crs_pkg::CRS_OP_COM: begin
                wide = {1'b1, ~a};
                flag_mask = 8'h1f;
            end
            crs_pkg::CRS_OP_NEG: begin
                wide = 9'h000 - {1'b0, a};
                sub  = 1'b1;
                flag_mask = 8'h3f;
            end
            crs_pkg::CRS_OP_INC: wide = {1'b0, a + 8'h01};
            crs_pkg::CRS_OP_DEC: wide = {1'b0, a - 8'h01};
            crs_pkg::CRS_OP_LSR: wide = {a[0], 1'b0, a[7:1]};
            crs_pkg::CRS_OP_ROR: wide = {a[0], cin, a[7:1]};
            crs_pkg::CRS_OP_ASR: wide = {a[0], a[7], a[7:1]};
        endcase
        res = wide[7:0];
        c   = wide[8];
        if (op == crs_pkg::CRS_OP_LSR || op == crs_pkg::CRS_OP_ROR ||
            op == crs_pkg::CRS_OP_ASR) begin
            flag_mask = 8'h1f;
            v = res[7] ^ c;
        end else if (op == crs_pkg::CRS_OP_INC) begin
            v = (res == 8'h80);
        end else if (op == crs_pkg::CRS_OP_DEC) begin
            v = (res == 8'h7f);
        end else if (op == crs_pkg::CRS_OP_NEG) begin
            v = (res == 8'h80);
            h = res[3] | a[3];
            c = (res != 8'h00);
        end else if (sub) begin
            h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
        end else if (flag_mask[`CRS_FLAG_H]) begin
            h = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
            v = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
        end
        flag_val = 8'h00;
        flag_val[`CRS_FLAG_H] = h;
        flag_val[`CRS_FLAG_V] = v;
        flag_val[`CRS_FLAG_N] = res[7];
        // Carry-chained subtracts keep zero only if the earlier bytes were zero too.
        flag_val[`CRS_FLAG_Z] = (res == 8'h00) & (~zc | zin);
        flag_val[`CRS_FLAG_C] = c;
        flag_val[`CRS_FLAG_S] = res[7] ^ v;
    end

endmodule // crs_alu
`default_nettype wire

// ### crs_core_regs.sv
// Working registers, flag register, stack pointer and prefetch latch of the core.
`timescale 1ns/10ps
`default_nettype none
`include "crs_defines.svh"

module crs_core_regs (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic                   clk_en,
    input  wire logic [4:0]             rd_addr_a,
    input  wire logic [4:0]             rd_addr_b,
    input  wire logic [4:0]             rd_word_addr,
    output logic [7:0]                  rd_data_a,
    output logic [7:0]                  rd_data_b,
    output logic [15:0]                 rd_word,
    input  wire logic                   wr_byte_en,
    input  wire logic                   wr_word_en,
    input  wire logic [4:0]             wr_addr,
    input  wire logic [15:0]            wr_data,
    input  wire logic                   alu_en,
    input  wire crs_pkg::crs_alu_op_t   alu_op,
    input  wire logic                   alu_imm_sel,
    input  wire logic [7:0]             alu_imm,
    output logic [7:0]                  alu_result,
    input  wire logic                   bit_store_op,
    input  wire logic                   bit_load_op,
    input  wire logic [2:0]             bit_sel,
    input  wire logic                   ptr_en,
    input  wire logic [1:0]             ptr_sel,
    input  wire crs_pkg::crs_ptr_mode_t ptr_mode,
    input  wire logic [5:0]             ptr_disp,
    output logic [15:0]                 ptr_addr,
    input  wire logic [15:0]            ds_addr,
    input  wire logic                   ds_wr,
    input  wire logic [7:0]             ds_wdata,
    output logic                        ds_hit,
    output logic [7:0]                  ds_rdata,
    input  wire logic [5:0]             io_addr,
    input  wire logic                   io_wr,
    input  wire logic [7:0]             io_wdata,
    output logic                        io_hit,
    output logic [7:0]                  io_rdata,
    input  wire logic                   flags_wr,
    input  wire logic [7:0]             flags_wdata,
    output logic [7:0]                  status_flags,
    input  wire logic                   push_op,
    input  wire logic                   pop_op,
    input  wire logic                   sub_call_op,
    input  wire logic                   sub_return_op,
    input  wire logic                   irq_return_op,
    input  wire logic                   irq_taken,
    input  wire logic                   set_irq_enable_op,
    input  wire logic                   clear_irq_enable_op,
    input  wire logic                   irq_pending,
    output logic                        irq_accept,
    output logic [15:0]                 stack_pointer,
    input  wire logic                   fetch_valid,
    input  wire logic [15:0]            fetch_word,
    output logic [15:0]                 exec_word
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam crs_pkg::crs_state_t RESET_STATE = '{
        gpr:   {32{`CRS_GPR_RESET}},
        flags: `CRS_FLAGS_RESET,
        sp:    `CRS_SP_RESET,
        instr: `CRS_INSTR_RESET
    };

    crs_pkg::crs_state_t st_r;
    crs_pkg::crs_state_t st_nxt;

    logic [7:0]  op_b;
    logic [7:0]  alu_flag_val;
    logic [7:0]  alu_flag_mask;
    logic        alu_writes;
    logic [4:0]  ptr_lo;
    logic [4:0]  ptr_hi;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [4:0]  word_lo;
    logic [4:0]  word_hi;
    logic [4:0]  wr_lo;

    // ------------------------------------------------------------------
    // Arithmetic unit
    // ------------------------------------------------------------------
    // Operand b is either the second register or the immediate.
    assign op_b = alu_imm_sel ? alu_imm : st_r.gpr[rd_addr_b];

    crs_alu u_alu (
        .op        (alu_op),
        .a         (st_r.gpr[rd_addr_a]),
        .b         (op_b),
        .cin       (st_r.flags[`CRS_FLAG_C]),
        .zin       (st_r.flags[`CRS_FLAG_Z]),
        .res       (alu_result),
        .flag_val  (alu_flag_val),
        .flag_mask (alu_flag_mask),
        .writes    (alu_writes)
    );

    // ------------------------------------------------------------------
    // Read ports and address decode
    // ------------------------------------------------------------------
    assign word_lo = {rd_word_addr[4:1], 1'b0};
    assign word_hi = {rd_word_addr[4:1], 1'b1};
    assign wr_lo   = {wr_addr[4:1], 1'b0};

    assign rd_data_a = st_r.gpr[rd_addr_a];
    assign rd_data_b = st_r.gpr[rd_addr_b];
    assign rd_word   = {st_r.gpr[word_hi], st_r.gpr[word_lo]};

    // Pointer pairs sit on even register boundaries, low byte first.
    always_comb begin
        unique case (ptr_sel)
            2'h0:    ptr_lo = `CRS_PTR_FIRST_LO;
            2'h1:    ptr_lo = `CRS_PTR_SECOND_LO;
            default: ptr_lo = `CRS_PTR_THIRD_LO;
        endcase
    end

    assign ptr_hi  = {ptr_lo[4:1], 1'b1};
    assign ptr_val = {st_r.gpr[ptr_hi], st_r.gpr[ptr_lo]};

    always_comb begin
        ptr_addr = ptr_val;
        ptr_new  = ptr_val;
        unique case (ptr_mode)
            crs_pkg::CRS_PTR_PLAIN: begin
                ptr_addr = ptr_val;
            end
            crs_pkg::CRS_PTR_DISP: begin
                ptr_addr = ptr_val + {10'h000, ptr_disp};
            end
            crs_pkg::CRS_PTR_POSTINC: begin
                ptr_new = ptr_val + `CRS_PTR_STEP;
            end
            crs_pkg::CRS_PTR_PREDEC: begin
                ptr_addr = ptr_val - `CRS_PTR_STEP;
                ptr_new  = ptr_val - `CRS_PTR_STEP;
            end
        endcase
    end

    assign ds_hit   = (ds_addr <= `CRS_DS_GPR_LAST);
    assign ds_rdata = ds_hit ? st_r.gpr[ds_addr[4:0]] : 8'h00;

    assign io_hit = (io_addr == `CRS_IO_SP_LOW) || (io_addr == `CRS_IO_SP_HIGH);

    always_comb begin
        if (io_addr == `CRS_IO_SP_LOW) begin
            io_rdata = st_r.sp[7:0];
        end else if (io_addr == `CRS_IO_SP_HIGH) begin
            io_rdata = st_r.sp[15:8];
        end else begin
            io_rdata = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // The decoder issues at most one register write source per cycle; when it
    // does not, later sources below win, except that a word write beats a byte
    // write, so the outcome is still defined.
    always_comb begin
        st_nxt = st_r;

        // Register writes.
        if (wr_word_en) begin
            st_nxt.gpr[wr_lo]           = wr_data[7:0];
            st_nxt.gpr[{wr_lo[4:1], 1'b1}] = wr_data[15:8];
        end else if (wr_byte_en) begin
            st_nxt.gpr[wr_addr] = wr_data[7:0];
        end
        if (ds_wr && ds_hit) begin
            st_nxt.gpr[ds_addr[4:0]] = ds_wdata;
        end
        if (ptr_en && (ptr_mode == crs_pkg::CRS_PTR_POSTINC ||
                       ptr_mode == crs_pkg::CRS_PTR_PREDEC)) begin
            st_nxt.gpr[ptr_lo] = ptr_new[7:0];
            st_nxt.gpr[ptr_hi] = ptr_new[15:8];
        end
        if (bit_load_op) begin
            st_nxt.gpr[rd_addr_a][bit_sel] = st_r.flags[`CRS_FLAG_T];
        end
        // Result and flags land at the same edge.
        if (alu_en && alu_writes) begin
            st_nxt.gpr[rd_addr_a] = alu_result;
        end

        // Flag register.
        if (flags_wr) begin
            st_nxt.flags = flags_wdata;
        end
        if (alu_en) begin
            st_nxt.flags = (st_r.flags & ~alu_flag_mask) |
                           (alu_flag_val & alu_flag_mask);
        end
        if (bit_store_op) begin
            st_nxt.flags[`CRS_FLAG_T] = st_r.gpr[rd_addr_a][bit_sel];
        end
        // Entry and return touch only the enable bit; the rest is software's job.
        if (clear_irq_enable_op) begin
            st_nxt.flags[`CRS_FLAG_I] = 1'b0;
        end
        if (set_irq_enable_op) begin
            st_nxt.flags[`CRS_FLAG_I] = 1'b1;
        end
        if (irq_taken) begin
            st_nxt.flags[`CRS_FLAG_I] = 1'b0;
        end
        if (irq_return_op) begin
            st_nxt.flags[`CRS_FLAG_I] = 1'b1;
        end
        // Sign is recomputed on every update, including software writes.
        st_nxt.flags[`CRS_FLAG_S] = st_nxt.flags[`CRS_FLAG_N] ^
                                    st_nxt.flags[`CRS_FLAG_V];

        // Stack pointer; the stack grows downward.
        if (push_op) begin
            st_nxt.sp = st_r.sp - `CRS_SP_STEP_BYTE;
        end else if (sub_call_op || irq_taken) begin
            st_nxt.sp = st_r.sp - `CRS_SP_STEP_CALL;
        end else if (pop_op) begin
            st_nxt.sp = st_r.sp + `CRS_SP_STEP_BYTE;
        end else if (sub_return_op || irq_return_op) begin
            st_nxt.sp = st_r.sp + `CRS_SP_STEP_CALL;
        end
        // A software write to either byte overrides that byte of a stack step in the same cycle.
        if (io_wr && io_addr == `CRS_IO_SP_LOW) begin
            st_nxt.sp[7:0] = io_wdata;
        end
        if (io_wr && io_addr == `CRS_IO_SP_HIGH) begin
            st_nxt.sp[15:8] = io_wdata;
        end

        // The next word is latched while the current one executes.
        if (fetch_valid) begin
            st_nxt.instr = fetch_word;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // One undivided clock for everything; the enable only freezes state.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r <= RESET_STATE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign status_flags  = st_r.flags;
    assign stack_pointer = st_r.sp;
    assign exec_word     = st_r.instr;
    // A clear issued in the same cycle blocks acceptance at once.
    assign irq_accept = irq_pending & st_r.flags[`CRS_FLAG_I] &
                        ~clear_irq_enable_op;

endmodule // crs_core_regs
`default_nettype wire

// ### crs_core_regs_chk_assertions.sv
// Concurrent checks on the ports of the register, flag and stack pointer datapath.
`timescale 1ns/10ps
`default_nettype none
module crs_core_regs_chk (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic        push_op,
    input wire logic        pop_op,
    input wire logic        sub_call_op,
    input wire logic        sub_return_op,
    input wire logic        irq_return_op,
    input wire logic        irq_taken,
    input wire logic        io_wr,
    input wire logic [15:0] stack_pointer,
    input wire logic [7:0]  status_flags,
    input wire logic        irq_pending,
    input wire logic        irq_accept,
    input wire logic        bit_store_op,
    input wire logic [2:0]  bit_sel,
    input wire logic [7:0]  rd_data_a,
    input wire logic        fetch_valid,
    input wire logic [15:0] fetch_word,
    input wire logic [15:0] exec_word
);
    // ----------------------------------------
    // Stack pointer, flag and prefetch checks
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic sel_bit;
    assign sel_bit = rd_data_a[bit_sel];
    // An I/O write may override a step, so those cycles are left out of the step checks.
    sequence s_push; clk_en && push_op && !io_wr; endsequence
    sequence s_call; clk_en && !push_op && !io_wr && (sub_call_op || irq_taken); endsequence
    sequence s_pop; clk_en && !io_wr && pop_op && !(push_op || sub_call_op || irq_taken); endsequence
    sequence s_return;
        clk_en && !io_wr && (sub_return_op || irq_return_op)
            && !(push_op || sub_call_op || irq_taken || pop_op);
    endsequence
    a_sp_push_one: assert property (s_push |=> stack_pointer == $past(stack_pointer) - 16'h0001)
        else $error("push step wrong");
    a_sp_call_two: assert property (s_call |=> stack_pointer == $past(stack_pointer) - 16'h0002)
        else $error("call step wrong");
    a_sp_pop_one: assert property (s_pop |=> stack_pointer == $past(stack_pointer) + 16'h0001)
        else $error("pop step wrong");
    a_sp_return_two: assert property (s_return |=> stack_pointer == $past(stack_pointer) + 16'h0002)
        else $error("return step wrong");
    a_sign_xor: assert property (status_flags[4] == (status_flags[2] ^ status_flags[3]))
        else $error("sign flag wrong");
    a_irq_gate: assert property (irq_accept |-> status_flags[7] && irq_pending)
        else $error("interrupt accepted while gated");
    a_irq_entry_clr: assert property (clk_en && irq_taken && !irq_return_op |-> ##1 !status_flags[7])
        else $error("enable not cleared on entry");
    a_return_set: assert property (clk_en && irq_return_op |=> status_flags[7])
        else $error("enable not set on return");
    a_bit_copy: assert property (clk_en && bit_store_op |=> status_flags[6] == $past(sel_bit))
        else $error("bit copy flag wrong");
    a_exec_fetch: assert property (clk_en && fetch_valid |=> exec_word == $past(fetch_word))
        else $error("prefetched word lost");
endmodule // crs_core_regs_chk
bind crs_core_regs crs_core_regs_chk i_chk (.*);
`default_nettype wire

// ### crs_defines.svh
// Constants for the working-register, flag and stack-pointer datapath.
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

`define CRS_PTR_FIRST_LO   5'h1a
`define CRS_PTR_SECOND_LO  5'h1c
`define CRS_PTR_THIRD_LO   5'h1e
`define CRS_DS_GPR_LAST    16'h001f
`define CRS_IO_SP_LOW      6'h3d
`define CRS_IO_SP_HIGH     6'h3e
`define CRS_STACK_FLOOR    16'h0060

`define CRS_FLAG_I         7
`define CRS_FLAG_T         6
`define CRS_FLAG_H         5
`define CRS_FLAG_S         4
`define CRS_FLAG_V         3
`define CRS_FLAG_N         2
`define CRS_FLAG_Z         1
`define CRS_FLAG_C         0

`define CRS_SP_RESET       16'h0000
`define CRS_FLAGS_RESET    8'h00
`define CRS_GPR_RESET      8'h00
`define CRS_INSTR_RESET    16'h0000

`define CRS_SP_STEP_BYTE   16'h0001
`define CRS_SP_STEP_CALL   16'h0002
`define CRS_PTR_STEP       16'h0001

`endif

// ### crs_fetch_model.sv
// Fetch side of the decode logic, offering one instruction word per cycle.
`timescale 1ns/10ps
`default_nettype none
module crs_fetch_model (
    input wire logic    sys_clk,
    input wire logic    run,
    output logic        fetch_valid,
    output logic [15:0] fetch_word
);
    // ----------------------------------------
    // Word source
    // ----------------------------------------
    logic [15:0] lfsr_r;
    initial begin
        lfsr_r = 16'h1ace;
        fetch_valid = 1'b0;
        fetch_word = 16'h0000;
    end
    // Outside a run the word flips every cycle, so a stale value is never mistaken for data.
    always @(posedge sys_clk) begin
        #2;
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13]};
        fetch_valid = run;
        fetch_word = run ? lfsr_r : ~fetch_word;
    end
endmodule // crs_fetch_model
`default_nettype wire

// ### crs_pkg.sv
// Types shared by the register datapath and its arithmetic unit.
package crs_pkg;

    typedef enum logic [3:0] {
        CRS_OP_ADD  = 4'h0,
        CRS_OP_ADC  = 4'h1,
        CRS_OP_SUB  = 4'h2,
        CRS_OP_SBC  = 4'h3,
        CRS_OP_AND  = 4'h4,
        CRS_OP_OR   = 4'h5,
        CRS_OP_EOR  = 4'h6,
        CRS_OP_COM  = 4'h7,
        CRS_OP_NEG  = 4'h8,
        CRS_OP_INC  = 4'h9,
        CRS_OP_DEC  = 4'ha,
        CRS_OP_LSR  = 4'hb,
        CRS_OP_ROR  = 4'hc,
        CRS_OP_ASR  = 4'hd,
        CRS_OP_CMP  = 4'he,
        CRS_OP_CPC  = 4'hf
    } crs_alu_op_t;

    typedef enum logic [1:0] {
        CRS_PTR_PLAIN   = 2'h0,
        CRS_PTR_DISP    = 2'h1,
        CRS_PTR_POSTINC = 2'h2,
        CRS_PTR_PREDEC  = 2'h3
    } crs_ptr_mode_t;

    typedef struct packed {
        logic [31:0][7:0] gpr;
        logic [7:0]       flags;
        logic [15:0]      sp;
        logic [15:0]      instr;
    } crs_state_t;

endpackage
